// File: eeprom_scan_addr.sv
`timescale 1ns/1ns
`default_nettype none

module eeprom_scan_addr (
   // Clock and reset
   input wire logic clock_i,
   input wire logic reset_n_i,
   // Strap pins
   input wire logic mem_addr_width_sel_i,
   input wire logic strap_pin_b_bit3_i,
   input wire logic strap_pin_c_bit3_i,
   input wire logic [3:0] strap_pin_d_code_i,
   // Byte read port to the serial engine
   output logic rd_req_o,
   output logic [scan_pkg::ADDR_W-1:0] rd_addr_o,
   input wire logic rd_ack_i,
   input wire logic [7:0] rd_data_i,
   // Scan status
   output logic scan_done_o,
   output logic found_o,
   output logic [scan_pkg::ADDR_W-1:0] found_addr_o,
   // Avalon-MM slave
   input wire logic [scan_pkg::BUS_AW-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o
);

   // ****************************************************
   // Strap synchronisers
   // ****************************************************
   logic [6:0] strap_meta;
   logic [6:0] strap_sync;

   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         strap_meta <= 7'h00;
         strap_sync <= 7'h00;
      end else begin
         strap_meta <= {mem_addr_width_sel_i, strap_pin_b_bit3_i,
                        strap_pin_c_bit3_i, strap_pin_d_code_i};
         strap_sync <= strap_meta;
      end
   end

   // ****************************************************
   // State
   // ****************************************************
   scan_pkg::scan_state_t state;
   scan_pkg::scan_state_t next_state;
   logic [1:0] settle_cnt;
   logic [1:0] next_settle_cnt;
   logic cfg_wide;
   logic next_cfg_wide;
   logic [1:0] cfg_size;
   logic [1:0] next_cfg_size;
   logic [3:0] cfg_step;
   logic [3:0] next_cfg_step;
   logic [scan_pkg::ADDR_W-1:0] probe_addr;
   logic [scan_pkg::ADDR_W-1:0] next_probe_addr;
   logic [1:0] byte_idx;
   logic [1:0] next_byte_idx;
   logic rd_req;
   logic next_rd_req;
   logic [scan_pkg::ADDR_W-1:0] rd_addr;
   logic [scan_pkg::ADDR_W-1:0] next_rd_addr;
   logic [scan_pkg::ADDR_W-1:0] found_addr;
   logic [scan_pkg::ADDR_W-1:0] next_found_addr;
   logic [scan_pkg::ADDR_W-1:0] ptr_addr;
   logic [scan_pkg::ADDR_W-1:0] next_ptr_addr;
   logic [7:0] ptr_data;
   logic [7:0] next_ptr_data;
   logic waitreq;
   logic next_waitreq;
   logic [31:0] rdata;
   logic [31:0] next_rdata;

   // ****************************************************
   // Increment and range decode
   // ****************************************************
   logic [scan_pkg::INC_W-1:0] auto_inc;
   logic [scan_pkg::INC_W-1:0] raw_inc;
   logic [scan_pkg::LIM_W-1:0] scan_limit;
   logic [scan_pkg::LIM_W-1:0] eff_inc;
   logic [scan_pkg::LIM_W-1:0] next_probe_sum;
   logic [7:0] sig_byte;

   always_comb begin
      unique case ({cfg_wide, cfg_size})
         3'h0: begin
            scan_limit = scan_pkg::LIMIT_N0;
            auto_inc = scan_pkg::AUTO_N0;
         end
         3'h1: begin
            scan_limit = scan_pkg::LIMIT_N1;
            auto_inc = scan_pkg::AUTO_N1;
         end
         3'h2: begin
            scan_limit = scan_pkg::LIMIT_N2;
            auto_inc = scan_pkg::AUTO_N2;
         end
         3'h3: begin
            scan_limit = scan_pkg::LIMIT_N3;
            auto_inc = scan_pkg::AUTO_N3;
         end
         3'h4: begin
            scan_limit = scan_pkg::LIMIT_W0;
            auto_inc = scan_pkg::AUTO_W0;
         end
         3'h5: begin
            scan_limit = scan_pkg::LIMIT_W1;
            auto_inc = scan_pkg::AUTO_W1;
         end
         3'h6: begin
            scan_limit = scan_pkg::LIMIT_W2;
            auto_inc = scan_pkg::AUTO_W2;
         end
         3'h7: begin
            scan_limit = scan_pkg::LIMIT_W3;
            auto_inc = scan_pkg::AUTO_W3;
         end
      endcase

      // Scales the automatic value, never replaces it
      if (cfg_step == scan_pkg::STEP_AUTO_LO ||
          cfg_step == scan_pkg::STEP_AUTO_HI) begin
         raw_inc = auto_inc;
      end else if (!cfg_step[scan_pkg::STEP_DIR_BIT]) begin
         raw_inc = auto_inc << cfg_step[2:0];
      end else begin
         raw_inc = auto_inc >> cfg_step[2:0];
      end

      // A zero step would spin forever on one probe
      if (raw_inc == '0) begin
         eff_inc = scan_limit - (scan_limit - 17'h00001);
      end else if (raw_inc > {3'h0, scan_limit}) begin
         eff_inc = scan_limit;
      end else begin
         eff_inc = raw_inc[scan_pkg::LIM_W-1:0];
      end

      next_probe_sum = {1'b0, probe_addr} + eff_inc;

      unique case (byte_idx)
         2'h0: sig_byte = scan_pkg::SIG_B0;
         2'h1: sig_byte = scan_pkg::SIG_B1;
         2'h2: sig_byte = scan_pkg::SIG_B2;
         2'h3: sig_byte = scan_pkg::SIG_B3;
      endcase
   end

   // ****************************************************
   // Bus decode
   // ****************************************************
   logic bus_req;
   logic bus_take;
   logic restart_wr;
   logic ptr_wr;

   assign bus_req = avs_read_i || avs_write_i;
   // Request is acted on at the edge where waitrequest is seen low
   assign bus_take = bus_req && !waitreq;
   assign restart_wr = bus_take && avs_write_i &&
                       avs_address_i == scan_pkg::REG_CTRL &&
                       avs_writedata_i[scan_pkg::CTRL_RESTART];
   assign ptr_wr = bus_take && avs_write_i &&
                   avs_address_i == scan_pkg::REG_PTR_ADDR;

   // ****************************************************
   // Next-state logic
   // ****************************************************
   always_comb begin
      next_state = state;
      next_settle_cnt = settle_cnt;
      next_cfg_wide = cfg_wide;
      next_cfg_size = cfg_size;
      next_cfg_step = cfg_step;
      next_probe_addr = probe_addr;
      next_byte_idx = byte_idx;
      next_rd_req = rd_req;
      next_rd_addr = rd_addr;
      next_found_addr = found_addr;
      next_ptr_addr = ptr_addr;
      next_ptr_data = ptr_data;

      unique case (state)
         scan_pkg::ST_SETTLE: begin
            // Wait for the synchronisers to fill before latching
            if (settle_cnt == 2'(scan_pkg::SYNC_STAGES)) begin
               next_cfg_wide = strap_sync[6];
               next_cfg_size = strap_sync[5:4];
               next_cfg_step = strap_sync[3:0];
               next_probe_addr = '0;
               next_byte_idx = '0;
               next_rd_addr = '0;
               next_rd_req = 1'b1;
               next_state = scan_pkg::ST_PROBE;
            end else begin
               next_settle_cnt = settle_cnt + 2'h1;
            end
         end
         scan_pkg::ST_PROBE: begin
            if (rd_ack_i) begin
               if (rd_data_i == sig_byte) begin
                  if (byte_idx == scan_pkg::SIG_LAST) begin
                     next_found_addr = probe_addr;
                     next_rd_req = 1'b0;
                     next_state = scan_pkg::ST_FOUND;
                  end else begin
                     next_byte_idx = byte_idx + 2'h1;
                     next_rd_addr = probe_addr +
                                    {14'h0000, byte_idx} + 16'h0001;
                  end
               end else if (next_probe_sum >= scan_limit) begin
                  next_rd_req = 1'b0;
                  next_state = scan_pkg::ST_NONE;
               end else begin
                  next_probe_addr =
                     next_probe_sum[scan_pkg::ADDR_W-1:0];
                  next_byte_idx = '0;
                  next_rd_addr = next_probe_sum[scan_pkg::ADDR_W-1:0];
               end
            end
         end
         scan_pkg::ST_FOUND, scan_pkg::ST_NONE: begin
            // Serial port stays silent unless restarted or, in ST_FOUND, a pointer address is written
            if (restart_wr) begin
               next_probe_addr = '0;
               next_byte_idx = '0;
               next_rd_addr = '0;
               next_rd_req = 1'b1;
               next_state = scan_pkg::ST_PROBE;
            end else if (ptr_wr && state == scan_pkg::ST_FOUND) begin
               // No range check: pointers may lie past the limit
               next_ptr_addr = avs_writedata_i[scan_pkg::ADDR_W-1:0];
               next_rd_addr = avs_writedata_i[scan_pkg::ADDR_W-1:0];
               next_rd_req = 1'b1;
               next_state = scan_pkg::ST_PTR;
            end
         end
         scan_pkg::ST_PTR: begin
            if (rd_ack_i) begin
               next_ptr_data = rd_data_i;
               next_rd_req = 1'b0;
               next_state = scan_pkg::ST_FOUND;
            end
         end
      endcase
   end

   // ****************************************************
   // Register read data and handshake
   // ****************************************************
   always_comb begin
      next_waitreq = 1'b1;
      next_rdata = rdata;
      if (bus_req && waitreq) begin
         next_waitreq = 1'b0;
         next_rdata = '0;
         if (avs_read_i) begin
            unique case (avs_address_i)
               scan_pkg::REG_STATUS: begin
                  next_rdata[0] = state == scan_pkg::ST_PROBE;
                  next_rdata[1] = state == scan_pkg::ST_FOUND ||
                                  state == scan_pkg::ST_PTR;
                  next_rdata[2] = state == scan_pkg::ST_NONE;
                  next_rdata[3] = state == scan_pkg::ST_PTR;
                  next_rdata[4] = state != scan_pkg::ST_SETTLE;
               end
               scan_pkg::REG_CONFIG: begin
                  next_rdata[6:0] = {cfg_step, cfg_size, cfg_wide};
               end
               scan_pkg::REG_INCR: begin
                  next_rdata[scan_pkg::LIM_W-1:0] = eff_inc;
               end
               scan_pkg::REG_FOUND: begin
                  next_rdata[scan_pkg::ADDR_W-1:0] = found_addr;
               end
               scan_pkg::REG_PTR_ADDR: begin
                  next_rdata[scan_pkg::ADDR_W-1:0] = ptr_addr;
               end
               scan_pkg::REG_PTR_DATA: begin
                  next_rdata[7:0] = ptr_data;
               end
               default: begin
                  next_rdata = '0;
               end
            endcase
         end
      end
   end

   // ****************************************************
   // Registers
   // ****************************************************
   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         state <= scan_pkg::ST_SETTLE;
         settle_cnt <= 2'h0;
         cfg_wide <= 1'b0;
         cfg_size <= 2'h0;
         cfg_step <= 4'h0;
         probe_addr <= '0;
         byte_idx <= 2'h0;
         rd_req <= 1'b0;
         rd_addr <= '0;
         found_addr <= '0;
         ptr_addr <= '0;
         ptr_data <= 8'h00;
         waitreq <= 1'b1;
         rdata <= 32'h0000_0000;
         scan_done_o <= 1'b0;
         found_o <= 1'b0;
      end else begin
         state <= next_state;
         settle_cnt <= next_settle_cnt;
         cfg_wide <= next_cfg_wide;
         cfg_size <= next_cfg_size;
         cfg_step <= next_cfg_step;
         probe_addr <= next_probe_addr;
         byte_idx <= next_byte_idx;
         rd_req <= next_rd_req;
         rd_addr <= next_rd_addr;
         found_addr <= next_found_addr;
         ptr_addr <= next_ptr_addr;
         ptr_data <= next_ptr_data;
         waitreq <= next_waitreq;
         rdata <= next_rdata;
         scan_done_o <= next_state == scan_pkg::ST_FOUND ||
                        next_state == scan_pkg::ST_PTR ||
                        next_state == scan_pkg::ST_NONE;
         found_o <= next_state == scan_pkg::ST_FOUND ||
                    next_state == scan_pkg::ST_PTR;
      end
   end

   // ****************************************************
   // Outputs
   // ****************************************************
   assign rd_req_o = rd_req;
   assign rd_addr_o = rd_addr;
   assign found_addr_o = found_addr;
   assign avs_readdata_o = rdata;
   assign avs_waitrequest_o = waitreq;

endmodule : eeprom_scan_addr

`default_nettype wire

// File: scan_pkg.sv
package scan_pkg;

   // ****************************************************
   // Widths
   // ****************************************************
   localparam int ADDR_W = 16;
   localparam int LIM_W = 17;
   localparam int INC_W = 20;
   localparam int BUS_AW = 5;
   localparam int SYNC_STAGES = 2;

   // ****************************************************
   // Scan ranges and automatic increments
   // ****************************************************
   // Narrow addressing group (width select low)
   localparam logic [LIM_W-1:0] LIMIT_N0 = 17'h00100;
   localparam logic [LIM_W-1:0] LIMIT_N1 = 17'h00200;
   localparam logic [LIM_W-1:0] LIMIT_N2 = 17'h00400;
   localparam logic [LIM_W-1:0] LIMIT_N3 = 17'h00800;
   localparam logic [INC_W-1:0] AUTO_N0 = 20'h00020;
   localparam logic [INC_W-1:0] AUTO_N1 = 20'h00040;
   localparam logic [INC_W-1:0] AUTO_N2 = 20'h00080;
   localparam logic [INC_W-1:0] AUTO_N3 = 20'h00200;
   // Wide addressing group (width select high)
   localparam logic [LIM_W-1:0] LIMIT_W0 = 17'h01000;
   localparam logic [LIM_W-1:0] LIMIT_W1 = 17'h02000;
   localparam logic [LIM_W-1:0] LIMIT_W2 = 17'h04000;
   localparam logic [LIM_W-1:0] LIMIT_W3 = 17'h08000;
   localparam logic [INC_W-1:0] AUTO_W0 = 20'h00200;
   localparam logic [INC_W-1:0] AUTO_W1 = 20'h00400;
   localparam logic [INC_W-1:0] AUTO_W2 = 20'h00800;
   localparam logic [INC_W-1:0] AUTO_W3 = 20'h01000;

   localparam logic [3:0] STEP_AUTO_LO = 4'h0;
   localparam logic [3:0] STEP_AUTO_HI = 4'hf;
   localparam int STEP_DIR_BIT = 3;

   // ****************************************************
   // Signature header bytes
   // ****************************************************
   localparam logic [7:0] SIG_B0 = 8'hee;
   localparam logic [7:0] SIG_B1 = 8'hc0;
   localparam logic [7:0] SIG_B2 = 8'hde;
   localparam logic [7:0] SIG_B3 = 8'h1f;
   localparam logic [1:0] SIG_LAST = 2'h3;

   // ****************************************************
   // Register map (byte addresses)
   // ****************************************************
   localparam logic [BUS_AW-1:0] REG_CTRL = 5'h00;
   localparam logic [BUS_AW-1:0] REG_STATUS = 5'h04;
   localparam logic [BUS_AW-1:0] REG_CONFIG = 5'h08;
   localparam logic [BUS_AW-1:0] REG_INCR = 5'h0c;
   localparam logic [BUS_AW-1:0] REG_FOUND = 5'h10;
   localparam logic [BUS_AW-1:0] REG_PTR_ADDR = 5'h14;
   localparam logic [BUS_AW-1:0] REG_PTR_DATA = 5'h18;
   localparam int CTRL_RESTART = 0;

   // ****************************************************
   // Scan sequencer states
   // ****************************************************
   typedef enum logic [4:0] {
      ST_SETTLE = 5'h01,
      ST_PROBE = 5'h02,
      ST_FOUND = 5'h04,
      ST_NONE = 5'h08,
      ST_PTR = 5'h10
   } scan_state_t;

endpackage : scan_pkg

// File: eeprom_scan_addr_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module eeprom_scan_addr_assertions (
   // Clock and reset
   input wire logic clock_i,
   input wire logic reset_n_i,
   // Straps
   input wire logic mem_addr_width_sel_i,
   input wire logic strap_pin_b_bit3_i,
   input wire logic strap_pin_c_bit3_i,
   input wire logic [3:0] strap_pin_d_code_i,
   // Read port
   input wire logic rd_req_o,
   input wire logic [scan_pkg::ADDR_W-1:0] rd_addr_o,
   input wire logic rd_ack_i,
   input wire logic [7:0] rd_data_i,
   // Status
   input wire logic scan_done_o,
   input wire logic found_o,
   input wire logic [scan_pkg::ADDR_W-1:0] found_addr_o,
   // Bus
   input wire logic [scan_pkg::BUS_AW-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o
);
   // ******************
   // Properties
   // ******************
   default clocking cb @(posedge clock_i);
   endclocking
   property p_reset;
      !reset_n_i |=> !rd_req_o && !scan_done_o && !found_o && avs_waitrequest_o;
   endproperty
   a_reset: assert property (p_reset)
      else $error("reset values wrong");
   // Settings need two sync stages before the first probe
   property p_first;
      disable iff (!reset_n_i) $rose(reset_n_i) |-> !rd_req_o [*2]
         ##[1:3] (rd_req_o && rd_addr_o == 16'h0000);
   endproperty
   a_first: assert property (p_first)
      else $error("first probe wrong");
   property p_hold;
      disable iff (!reset_n_i) rd_req_o && !rd_ack_i |=>
         rd_req_o && $stable(rd_addr_o);
   endproperty
   a_hold: assert property (p_hold)
      else $error("request dropped");
   property p_advance;
      disable iff (!reset_n_i) rd_req_o && rd_ack_i && !found_o |=>
         !rd_req_o || rd_addr_o > $past(rd_addr_o);
   endproperty
   a_advance: assert property (p_advance)
      else $error("probe address not advancing");
   property p_found;
      disable iff (!reset_n_i) $rose(found_o) |->
         $past(rd_ack_i) && $past(rd_data_i) == 8'h1f && scan_done_o;
   endproperty
   a_found: assert property (p_found)
      else $error("found without header end");
   property p_found_addr;
      disable iff (!reset_n_i) $rose(found_o) |->
         found_addr_o + 16'h0003 == $past(rd_addr_o);
   endproperty
   a_found_addr: assert property (p_found_addr)
      else $error("found address wrong");
   property p_no_more;
      disable iff (!reset_n_i) scan_done_o && !found_o |-> !rd_req_o;
   endproperty
   a_no_more: assert property (p_no_more)
      else $error("read after failed scan");
   property p_wait_one;
      disable iff (!reset_n_i) (avs_read_i || avs_write_i) &&
         avs_waitrequest_o |=> !avs_waitrequest_o;
   endproperty
   a_wait_one: assert property (p_wait_one)
      else $error("bus answer late");
   property p_wait_pulse;
      disable iff (!reset_n_i) !avs_waitrequest_o |=> avs_waitrequest_o;
   endproperty
   a_wait_pulse: assert property (p_wait_pulse)
      else $error("bus accept too long");
endmodule : eeprom_scan_addr_assertions

bind eeprom_scan_addr eeprom_scan_addr_assertions chk (
   .clock_i(clock_i), .reset_n_i(reset_n_i),
   .mem_addr_width_sel_i(mem_addr_width_sel_i),
   .strap_pin_b_bit3_i(strap_pin_b_bit3_i),
   .strap_pin_c_bit3_i(strap_pin_c_bit3_i),
   .strap_pin_d_code_i(strap_pin_d_code_i),
   .rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o), .rd_ack_i(rd_ack_i),
   .rd_data_i(rd_data_i), .scan_done_o(scan_done_o), .found_o(found_o),
   .found_addr_o(found_addr_o), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o));
`default_nettype wire

// File: eeprom_model.sv
`timescale 1ns/1ns
`default_nettype none
module eeprom_model (
   // Clock and reset
   input wire logic clock_i,
   input wire logic reset_n_i,
   // Byte read port
   input wire logic rd_req_i,
   input wire logic [15:0] rd_addr_i,
   input wire logic [3:0] delay_i,
   output logic rd_ack_o,
   output logic [7:0] rd_data_o
);
   logic [7:0] mem [0:65535];
   logic [3:0] wait_cnt;
   initial begin
      foreach (mem[i]) mem[i] = 8'h00;
      rd_ack_o = 1'b0;
      rd_data_o = 8'h00;
      wait_cnt = 4'h0;
   end
   // Data toggles outside the ack so a stale byte never passes
   always @(posedge clock_i) begin
      rd_ack_o <= 1'b0;
      rd_data_o <= ~rd_data_o;
      if (!reset_n_i) begin
         wait_cnt <= 4'h0;
      end else if (rd_req_i && !rd_ack_o) begin
         if (wait_cnt >= delay_i) begin
            rd_ack_o <= 1'b1;
            rd_data_o <= mem[rd_addr_i];
            wait_cnt <= 4'h0;
         end else begin
            wait_cnt <= wait_cnt + 4'h1;
         end
      end
   end
endmodule : eeprom_model
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   // ******************
   // Bench
   // ******************
   logic clock_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic w_sel = 1'b0;
   logic sz_b = 1'b0;
   logic sz_c = 1'b0;
   logic [3:0] step = 4'h0;
   logic [3:0] delay = 4'h0;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic rd_req, rd_ack, scan_done, found, avs_waitrequest;
   logic [15:0] rd_addr, found_addr, mon_addr, mon_base;
   logic [7:0] rd_data;
   logic [31:0] avs_readdata, d;
   logic [16:0] mon_inc;
   logic mon_on = 1'b0;
   int mon_idx, probes;
   int err_total = 0;
   int checks_done = 0;
   logic [7:0] sig_b [4] = '{8'hee, 8'hc0, 8'hde, 8'h1f};

   initial begin
      forever #20 clock_i = ~clock_i;
   end

   eeprom_scan_addr uut (.clock_i(clock_i), .reset_n_i(reset_n_i),
      .mem_addr_width_sel_i(w_sel), .strap_pin_b_bit3_i(sz_b),
      .strap_pin_c_bit3_i(sz_c), .strap_pin_d_code_i(step),
      .rd_req_o(rd_req), .rd_addr_o(rd_addr), .rd_ack_i(rd_ack),
      .rd_data_i(rd_data), .scan_done_o(scan_done), .found_o(found),
      .found_addr_o(found_addr), .avs_address_i(avs_address),
      .avs_read_i(avs_read), .avs_write_i(avs_write),
      .avs_writedata_i(avs_writedata), .avs_readdata_o(avs_readdata),
      .avs_waitrequest_o(avs_waitrequest));
   eeprom_model partner (.clock_i(clock_i), .reset_n_i(reset_n_i),
      .rd_req_i(rd_req), .rd_addr_i(rd_addr), .delay_i(delay),
      .rd_ack_o(rd_ack), .rd_data_o(rd_data));

   task automatic chk(input logic [31:0] got, exp, input string what);
      checks_done++;
      if (got !== exp) begin
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
         err_total++;
      end
   endtask : chk

   task automatic give_verdict();
      if (err_total == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : give_verdict

   function automatic logic [16:0] exp_inc(input logic w,
      input logic [1:0] s, input logic [3:0] st);
      logic [31:0] a;
      logic [31:0] lim;
      lim = (w ? 32'h00001000 : 32'h00000100) << s;
      a = (w ? 32'h00000200 : 32'h00000020) << s;
      if (!w && s == 2'h3) a = 32'h00000200;
      if (st != 4'h0 && st != 4'hf) a = st[3] ? a >> st[2:0] : a << st[2:0];
      if (a == 32'h0) a = 32'h00000001;
      if (a > lim) a = lim;
      return a[16:0];
   endfunction : exp_inc

   task automatic avs_rd(input logic [4:0] a, output logic [31:0] q);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge clock_i); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      @(posedge clock_i);
   endtask : avs_rd

   task automatic avs_wr(input logic [4:0] a, input logic [31:0] v);
      avs_address <= a;
      avs_writedata <= v;
      avs_write <= 1'b1;
      do @(posedge clock_i); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      @(posedge clock_i);
   endtask : avs_wr

   task automatic do_reset(input logic w, input logic [1:0] s,
      input logic [3:0] st);
      mon_on = 1'b0;
      reset_n_i <= 1'b0;
      w_sel <= w;
      sz_b <= s[1];
      sz_c <= s[0];
      step <= st;
      repeat (6) @(posedge clock_i);
      reset_n_i <= 1'b1;
   endtask : do_reset

   task automatic mon_init(input logic [16:0] inc);
      mon_inc = inc;
      mon_idx = 0;
      probes = 0;
      mon_base = 16'h0000;
      mon_addr = 16'h0000;
      mon_on = 1'b1;
   endtask : mon_init

   // Straps flipped mid-scan must not change the scan
   task automatic scan(input logic w, input logic [1:0] s,
      input logic [3:0] st, input logic [3:0] dl, input logic flip);
      delay <= dl;
      do_reset(w, s, st);
      mon_init(exp_inc(w, s, st));
      repeat (8) @(posedge clock_i);
      if (flip) begin
         w_sel <= ~w;
         sz_b <= ~s[1];
         step <= 4'h0;
      end
   endtask : scan

   task automatic wait_done(input logic f, input logic [15:0] fa,
      input int np);
      while (scan_done !== 1'b1) @(posedge clock_i);
      chk(32'(found), 32'(f), "found flag");
      if (f) chk(32'(found_addr), 32'(fa), "found address");
      chk(32'(probes), 32'(np), "probe count");
   endtask : wait_done

   always @(posedge clock_i) begin
      if (mon_on && rd_req === 1'b1 && rd_ack === 1'b1) begin
         chk(32'(rd_addr), 32'(mon_addr), "probe address");
         if (mon_idx == 0) probes++;
         if (rd_data === sig_b[mon_idx]) begin
            mon_idx++;
            mon_addr = rd_addr + 16'h0001;
            if (mon_idx == 4) mon_on = 1'b0;
         end else begin
            mon_idx = 0;
            mon_base = mon_base + mon_inc[15:0];
            mon_addr = mon_base;
         end
      end
   end

   initial begin
      repeat (20000) @(posedge clock_i);
      err_total++;
      give_verdict();
   end

   initial begin
      for (int i = 0; i < 128; i++) begin
         do_reset(i[6], i[5:4], i[3:0]);
         repeat (5) @(posedge clock_i);
         avs_rd(scan_pkg::REG_INCR, d);
         chk(32'(d[16:0]), 32'(exp_inc(i[6], i[5:4], i[3:0])), "incr");
         avs_rd(scan_pkg::REG_CONFIG, d);
         chk(32'(d[6:0]), 32'({i[3:0], i[5:4], i[6]}), "config");
      end
      partner.mem[0] = 8'hee;
      partner.mem[1] = 8'hc0;
      for (int k = 0; k < 4; k++) partner.mem[16'h0400 + k] = sig_b[k];
      for (int k = 0; k < 16; k++) partner.mem[16'h9000 + k] = 8'h5a;
      scan(1'b0, 2'h0, 4'h0, 4'h0, 1'b0);
      wait_done(1'b0, 16'h0000, 8);
      scan(1'b0, 2'h3, 4'h1, 4'h2, 1'b0);
      wait_done(1'b1, 16'h0400, 2);
      avs_rd(scan_pkg::REG_FOUND, d);
      chk(32'(d[15:0]), 32'h00000400, "found reg");
      avs_rd(scan_pkg::REG_STATUS, d);
      chk(32'(d[2:0]), 32'h00000002, "status");
      avs_rd(5'h1c, d);
      chk(d, 32'h00000000, "unmapped");
      avs_wr(scan_pkg::REG_PTR_ADDR, 32'h00009000);
      while (!(rd_req === 1'b1 && rd_ack === 1'b1)) @(posedge clock_i);
      chk(32'(rd_addr), 32'h00009000, "pointer address");
      repeat (4) @(posedge clock_i);
      avs_rd(scan_pkg::REG_PTR_DATA, d);
      chk(32'(d[7:0]), 32'h0000005a, "pointer data");
      scan(1'b1, 2'h0, 4'hb, 4'h0, 1'b0);
      wait_done(1'b1, 16'h0400, 17);
      scan(1'b1, 2'h3, 4'hf, 4'h5, 1'b1);
      wait_done(1'b0, 16'h0000, 8);
      mon_init(17'h01000);
      avs_wr(scan_pkg::REG_CTRL, 32'h00000001);
      repeat (2) @(posedge clock_i);
      wait_done(1'b0, 16'h0000, 8);
      give_verdict();
   end
endmodule : tb
`default_nettype wire
